// file: logic/pmc_top.sv
// Per-port MAC control for a multi-port switch: one control register per
// port, reached indirectly from the CPU port and directly from I2C.
// Assumes a single 50 MHz clock and inputs synchronous to it.
//
// Functional notes
// - Register at CPU base+2n, I2C base+n.
// - Bit0 clear means flow control on.
// - Half duplex flow control uses back pressure.
// - Full duplex sends and honours pause frames.
// - Pause counter counts while flow control on.
// - Off in half duplex: no pause, no jam.
// - Off in full duplex: pauses ignored, uncounted.
// - Bit1 set selects half duplex.
// - Bit2 set selects 10 Mbps.
// - Mode 00 runs hardware auto-negotiation.
// - Mode 01 uses register, still polls PHY.
// - Mode 10 forces down, no PHY talk.
// - Mode 11 forces up, no PHY talk.
// - Asymmetric bit: honour pauses, never send.
// - Blocking and listening drop, no learning.
// - Learning state drops but learns.
// - Forwarding state forwards and learns.
// - Data register at address 2 moves bytes.
`timescale 1ns/10ps
`include "pmc_defs.svh"
module pmc_top #(
    parameter int NPORTS = 5,     // Number of switch ports.
    parameter int CNT_W  = 16     // Width of each pause frame counter.
) (
    input  wire logic                            clock_i,
    input  wire logic                            sys_rst_i,
    // Direct CPU port.
    input  wire logic [2:0]                      cpu_addr_i,
    input  wire logic                            cpu_wr_i,
    input  wire logic                            cpu_rd_i,
    input  wire logic [15:0]                     cpu_wdata_i,
    output logic [7:0]                           cpu_rdata_o,
    output logic                                 cpu_rvalid_o,
    // I2C register port, already decoded to byte accesses.
    input  wire logic [7:0]                      i2c_addr_i,
    input  wire logic                            i2c_wr_i,
    input  wire logic                            i2c_rd_i,
    input  wire logic [7:0]                      i2c_wdata_i,
    output logic [7:0]                           i2c_rdata_o,
    output logic                                 i2c_rvalid_o,
    // Per-port MAC and PHY side.
    input  wire logic [NPORTS-1:0]               frame_idle_i,
    input  wire logic [NPORTS-1:0]               rx_pause_i,
    input  wire logic [NPORTS-1:0]               congest_i,
    input  wire logic [NPORTS-1:0]               phy_link_i,
    input  wire logic [NPORTS-1:0]               aneg_half_i,
    input  wire logic [NPORTS-1:0]               aneg_ten_i,
    output pmc_pkg::pmc_stat_t [NPORTS-1:0]      stat_o,
    output logic [NPORTS-1:0][CNT_W-1:0]         pause_cnt_o
);
    logic [15:0]               idx_reg;       // Indirect address, write only.
    logic [NPORTS-1:0][7:0]    ctl_reg;       // Port control registers.
    logic [NPORTS-1:0][7:0]    ctl_next;      // Their next values.
    logic [NPORTS-1:0]         cpu_hit;       // Index selects this port.
    logic [NPORTS-1:0]         i2c_hit;       // I2C address selects this port.
    logic [NPORTS-1:0]         cpu_wr_hit;    // CPU data write to this port.
    logic [NPORTS-1:0]         i2c_wr_hit;    // I2C write to this port.
    pmc_pkg::pmc_cfg_t [NPORTS-1:0] act_cfg;  // Settings in force per port.
    logic [7:0]                cpu_rd_sel;    // Byte the CPU would read.
    logic [7:0]                i2c_rd_sel;    // Byte I2C would read.
    logic [7:0]                cpu_rdata_reg; // Held CPU read data.
    logic [7:0]                i2c_rdata_reg; // Held I2C read data.
    logic                      cpu_rvalid_reg;
    logic                      i2c_rvalid_reg;

    // Bus strobes decoded once.
    wire       idx_wr   = cpu_wr_i && (cpu_addr_i == `PMC_IDX_ADDR);
    wire       data_wr  = cpu_wr_i && (cpu_addr_i == `PMC_DATA_ADDR);
    wire       data_rd  = cpu_rd_i && (cpu_addr_i == `PMC_DATA_ADDR);
    // Offset from the base; odd offsets belong to the second control
    // register, which is not in this block and so reads as zero.
    wire [15:0] idx_off = idx_reg - `PMC_CPU_BASE;
    wire [7:0]  i2c_off = i2c_addr_i - `PMC_I2C_BASE;

    // Index register. Writing it has no other effect.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            idx_reg <= 16'h0000;
        end else if (idx_wr) begin
            idx_reg <= cpu_wdata_i;
        end
    end

    // One control register and one settings engine per port.
    for (genvar g = 0; g < NPORTS; g++) begin : g_port
        // CPU reaches port g at twice g, I2C at g, both above their bases.
        assign cpu_hit[g]    = (idx_off == 16'(2 * g));
        assign i2c_hit[g]    = (i2c_off == 8'(g));
        assign cpu_wr_hit[g] = data_wr && cpu_hit[g];
        assign i2c_wr_hit[g] = i2c_wr_i && i2c_hit[g];
        // A CPU write wins over an I2C write to the same port in one cycle.
        assign ctl_next[g]   = cpu_wr_hit[g] ? cpu_wdata_i[7:0] :
                               i2c_wr_hit[g] ? i2c_wdata_i : ctl_reg[g];

        // Register storage with the documented reset value.
        always_ff @(posedge clock_i) begin
            if (sys_rst_i) begin
                ctl_reg[g] <= `PMC_CTL_RESET;
            end else begin
                ctl_reg[g] <= ctl_next[g];
            end
        end

        // The engine takes new settings only between frames.
        pmc_port_ctl #(
            .CNT_W        (CNT_W)
        ) u_port (
            .clock_i      (clock_i),
            .sys_rst_i    (sys_rst_i),
            .cfg_i        (pmc_pkg::pmc_cfg_t'(ctl_reg[g])),
            .frame_idle_i (frame_idle_i[g]),
            .rx_pause_i   (rx_pause_i[g]),
            .congest_i    (congest_i[g]),
            .phy_link_i   (phy_link_i[g]),
            .aneg_half_i  (aneg_half_i[g]),
            .aneg_ten_i   (aneg_ten_i[g]),
            .act_cfg_o    (act_cfg[g]),
            .stat_o       (stat_o[g]),
            .pause_cnt_o  (pause_cnt_o[g])
        );
    end

    // Read selection: an address that selects no port yields zero.
    always_comb begin
        cpu_rd_sel = 8'h00;
        i2c_rd_sel = 8'h00;
        for (int p = 0; p < NPORTS; p++) begin
            if (cpu_hit[p]) begin
                cpu_rd_sel = cpu_rd_sel | ctl_reg[p];
            end
            if (i2c_hit[p]) begin
                i2c_rd_sel = i2c_rd_sel | ctl_reg[p];
            end
        end
    end

    // Read data is captured one cycle after the strobe and held until the
    // next read, so a slow host may sample it late.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            cpu_rdata_reg  <= 8'h00;
            cpu_rvalid_reg <= 1'b0;
        end else begin
            cpu_rvalid_reg <= data_rd;
            if (data_rd) begin
                cpu_rdata_reg <= cpu_rd_sel;
            end
        end
    end

    // Same for the I2C side, which has no index stage.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            i2c_rdata_reg  <= 8'h00;
            i2c_rvalid_reg <= 1'b0;
        end else begin
            i2c_rvalid_reg <= i2c_rd_i;
            if (i2c_rd_i) begin
                i2c_rdata_reg <= i2c_rd_sel;
            end
        end
    end

    assign cpu_rdata_o  = cpu_rdata_reg;
    assign cpu_rvalid_o = cpu_rvalid_reg;
    assign i2c_rdata_o  = i2c_rdata_reg;
    assign i2c_rvalid_o = i2c_rvalid_reg;

    // Checks on port 0; the other ports are copies of the same logic.
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (sys_rst_i);

    // Index load for port 0 followed by a data write to port 0; a host may
    // leave an idle cycle between the two strobes.
    sequence seq_idx0;
        idx_wr && (cpu_wdata_i == `PMC_CPU_BASE);
    endsequence
    sequence seq_data_wr;
        data_wr && cpu_hit[0];
    endsequence
    sequence seq_data_rd;
        data_rd && cpu_hit[0];
    endsequence

    // A reset cycle leaves port 0 at its default value.
    property p_reset_val;
        disable iff (1'b0) sys_rst_i |=> (ctl_reg[0] == `PMC_CTL_RESET);
    endproperty
    AST_RESET_VAL: assert property (p_reset_val)
        else $error("Port 0 register not at reset value.");

    AST_CPU_WRITE: assert property (
        seq_idx0 ##[1:2] seq_data_wr |=> (ctl_reg[0] == $past(cpu_wdata_i[7:0])))
        else $error("CPU indirect write did not reach port 0.");

    AST_I2C_WRITE: assert property (
        (i2c_wr_i && i2c_addr_i == `PMC_I2C_BASE && !cpu_wr_hit[0])
        |=> (ctl_reg[0] == $past(i2c_wdata_i)))
        else $error("I2C write did not reach port 0.");

    AST_CPU_READ: assert property (
        seq_data_rd |=> cpu_rvalid_o && (cpu_rdata_o == $past(ctl_reg[0])))
        else $error("CPU read of port 0 returned wrong data.");

    AST_HOLD_FRAME: assert property (
        !frame_idle_i[0] |=> $stable(act_cfg[0]))
        else $error("Settings changed inside a frame.");

    AST_DROP: assert property (
        (act_cfg[0].stp[1] == 1'b0) |=> !stat_o[0].fwd_en && !stat_o[0].learn_en)
        else $error("Blocking or listening port forwarded or learned.");

    AST_LEARN: assert property (
        (act_cfg[0].stp == `PMC_STP_LEARN) |=> !stat_o[0].fwd_en && stat_o[0].learn_en)
        else $error("Learning state handled frames wrongly.");

    AST_FORWARD: assert property (
        (act_cfg[0].stp == `PMC_STP_FWD) |=> stat_o[0].fwd_en && stat_o[0].learn_en)
        else $error("Forwarding state did not forward and learn.");

    AST_NO_TX_PAUSE: assert property (
        (act_cfg[0].fc_off || act_cfg[0].asym) |=> !stat_o[0].tx_pause_en)
        else $error("Pause frame sent while not allowed.");

    AST_NO_JAM: assert property (
        act_cfg[0].fc_off |=> !stat_o[0].bp_en && !stat_o[0].rx_pause_en)
        else $error("Flow control acted while turned off.");

    AST_CNT_FROZEN: assert property (
        (rx_pause_i[0] && act_cfg[0].fc_off) |=> $stable(pause_cnt_o[0]))
        else $error("Pause counter moved with flow control off.");

    AST_CNT_STEP: assert property (
        (rx_pause_i[0] && !act_cfg[0].fc_off)
        |=> (pause_cnt_o[0] == $past(pause_cnt_o[0]) + 1'b1))
        else $error("Pause counter missed a pause frame.");

    AST_FORCE_DOWN: assert property (
        (act_cfg[0].mode == `PMC_MODE_DOWN) |=> !stat_o[0].link_up && !stat_o[0].phy_poll)
        else $error("Forced-down port shows link or polls PHY.");

    AST_FORCE_UP: assert property (
        (act_cfg[0].mode == `PMC_MODE_UP)
        |=> stat_o[0].link_up && !stat_o[0].phy_poll
            && (stat_o[0].half_dup == $past(act_cfg[0].half)))
        else $error("Forced-up port not up from register settings.");

    AST_LIMITED: assert property (
        (act_cfg[0].mode == `PMC_MODE_LIMIT)
        |=> stat_o[0].phy_poll && !stat_o[0].aneg_run
            && (stat_o[0].ten_mb == $past(act_cfg[0].ten_mb)))
        else $error("Limited mode did not use register speed.");

    AST_BACKPRESS: assert property (
        (!act_cfg[0].fc_off && act_cfg[0].half && act_cfg[0].mode == `PMC_MODE_UP
         && congest_i[0]) |=> stat_o[0].bp_en && !stat_o[0].tx_pause_en)
        else $error("Half-duplex congestion without back pressure.");

    AST_FULL_PAUSE: assert property (
        (!act_cfg[0].fc_off && !act_cfg[0].half && !act_cfg[0].asym
         && act_cfg[0].mode == `PMC_MODE_UP && congest_i[0])
        |=> stat_o[0].tx_pause_en && stat_o[0].rx_pause_en)
        else $error("Full-duplex congestion without pause frame.");
endmodule // pmc_top

// file: logic/pmc_defs.svh
// Constants of the per-port MAC control block: offsets, fields, resets, codes.
// Assumes inclusion by its bare name from the block's modules and the bench.
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH
// Direct CPU port addresses.
`define PMC_IDX_ADDR   3'h0
`define PMC_DATA_ADDR  3'h2
// Indirect bases: CPU index base plus twice the port, I2C base plus the port.
`define PMC_CPU_BASE   16'h0000
`define PMC_I2C_BASE   8'h00
// Reset value of each port control register: forwarding, all else clear.
`define PMC_CTL_RESET  8'hc0
// Field positions inside the port control register.
`define PMC_FC_OFF_BIT 0
`define PMC_HALF_BIT   1
`define PMC_TEN_BIT    2
`define PMC_MODE_LSB   3
`define PMC_ASYM_BIT   5
`define PMC_STP_LSB    6
// Link mode codes.
`define PMC_MODE_ANEG  2'h0
`define PMC_MODE_LIMIT 2'h1
`define PMC_MODE_DOWN  2'h2
`define PMC_MODE_UP    2'h3
// Spanning-tree state codes.
`define PMC_STP_BLOCK  2'h0
`define PMC_STP_LISTEN 2'h1
`define PMC_STP_LEARN  2'h2
`define PMC_STP_FWD    2'h3
`endif

// file: logic/pmc_pkg.sv
// Types shared by the per-port MAC control block.
// Assumes the constants header is on the include path.
package pmc_pkg;
    // One port control register, most significant field first.
    typedef struct packed {
        logic [1:0] stp;       // Spanning-tree state.
        logic       asym;      // Receive-only pause handling.
        logic [1:0] mode;      // Link mode.
        logic       ten_mb;    // Set for 10 Mbps.
        logic       half;      // Set for half duplex.
        logic       fc_off;    // Set to turn flow control off.
    } pmc_cfg_t;
    // Per-port controls handed to the MAC, PHY poller and forwarding logic.
    typedef struct packed {
        logic link_up;      // Port treated as link up.
        logic phy_poll;     // Poller may talk to the PHY.
        logic aneg_run;     // Auto-negotiation machine runs.
        logic half_dup;     // Port runs half duplex.
        logic ten_mb;       // Port runs 10 Mbps.
        logic bp_en;        // Transmitter applies back pressure now.
        logic tx_pause_en;  // Transmitter sends a pause frame now.
        logic rx_pause_en;  // Receiver acts on pause frames.
        logic fwd_en;       // Received frames are forwarded.
        logic learn_en;     // Source addresses are learned.
    } pmc_stat_t;
endpackage

// file: logic/pmc_port_ctl.sv
// One port's settings engine: adopts the register at frame boundaries,
// derives MAC, PHY and forwarding controls, counts pause frames received with flow control on.
// Assumes frame_idle_i is high between frames and all inputs are synchronous.
`timescale 1ns/10ps
`include "pmc_defs.svh"
module pmc_port_ctl #(
    parameter int CNT_W = 16
) (
    input  wire logic              clock_i,
    input  wire logic              sys_rst_i,
    input  wire pmc_pkg::pmc_cfg_t cfg_i,
    input  wire logic              frame_idle_i,
    input  wire logic              rx_pause_i,
    input  wire logic              congest_i,
    input  wire logic              phy_link_i,
    input  wire logic              aneg_half_i,
    input  wire logic              aneg_ten_i,
    output pmc_pkg::pmc_cfg_t      act_cfg_o,
    output pmc_pkg::pmc_stat_t     stat_o,
    output logic [CNT_W-1:0]       pause_cnt_o
);
    pmc_pkg::pmc_cfg_t  act_reg;     // Settings in force for the current frame.
    pmc_pkg::pmc_stat_t stat_reg;    // Registered controls.
    pmc_pkg::pmc_stat_t stat_next;   // Controls for the next cycle.
    logic [CNT_W-1:0]   cnt_reg;     // Received pause frame count.
    wire fc_on   = ~act_reg.fc_off;
    wire m_aneg  = (act_reg.mode == `PMC_MODE_ANEG);
    wire m_down  = (act_reg.mode == `PMC_MODE_DOWN);
    wire m_up    = (act_reg.mode == `PMC_MODE_UP);
    // Forced down wins; forced up ignores the PHY; otherwise the PHY decides.
    wire link    = m_up | (~m_down & phy_link_i);
    // Auto-negotiation supplies speed and duplex; other modes use the register.
    wire half    = m_aneg ? aneg_half_i : act_reg.half;
    wire ten     = m_aneg ? aneg_ten_i : act_reg.ten_mb;
    wire rx_hon  = fc_on & ~half & link;

    // Derive the controls; the stat register keeps data outputs on flops.
    always_comb begin
        stat_next.link_up     = link;
        stat_next.phy_poll    = ~m_down & ~m_up;
        stat_next.aneg_run    = m_aneg;
        stat_next.half_dup    = half;
        stat_next.ten_mb      = ten;
        // Back pressure only; a port with flow control off never jams.
        stat_next.bp_en       = fc_on & half & link & congest_i;
        // Asymmetric mode keeps honouring pause frames but never sends one.
        stat_next.tx_pause_en = rx_hon & ~act_reg.asym & congest_i;
        stat_next.rx_pause_en = rx_hon;
        stat_next.fwd_en      = (act_reg.stp == `PMC_STP_FWD);
        stat_next.learn_en    = act_reg.stp[1];
    end

    // Settings change only between frames, so no frame sees mixed settings.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            act_reg <= pmc_pkg::pmc_cfg_t'(`PMC_CTL_RESET);
        end else if (frame_idle_i) begin
            act_reg <= cfg_i;
        end
    end

    // Controls and pause counter; the counter wraps rather than saturates.
    always_ff @(posedge clock_i) begin
        if (sys_rst_i) begin
            stat_reg <= '0;
            cnt_reg  <= '0;
        end else begin
            stat_reg <= stat_next;
            if (rx_pause_i && fc_on) begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end

    assign act_cfg_o   = act_reg;
    assign stat_o      = stat_reg;
    assign pause_cnt_o = cnt_reg;
endmodule // pmc_port_ctl

// file: test/pmc_phy_model.sv
// Behavioural PHY and remote link partner for the port MAC control bench.
// Assumes the bench asks for link state and single pause frames per port.
`timescale 1ns/10ps
module pmc_phy_model #(
    parameter int NPORTS = 5                    // Number of ports served.
) (
    input  wire logic              clock_i,
    input  wire logic              sys_rst_i,
    input  wire logic [NPORTS-1:0] link_req_i,  // Wanted link state.
    input  wire logic [NPORTS-1:0] pause_req_i, // Send one pause frame.
    output logic      [NPORTS-1:0] phy_link_o,  // Polled link status.
    output logic      [NPORTS-1:0] aneg_half_o, // Negotiated half duplex.
    output logic      [NPORTS-1:0] aneg_ten_o,  // Negotiated 10 Mbps.
    output logic      [NPORTS-1:0] rx_pause_o   // Pause frame pulse.
);
    // Odd ports negotiate half duplex, ports with bit 1 set negotiate 10 Mbps.
    // A pause frame only arrives while the link is up, as on a real wire.
    always_ff @(posedge clock_i) begin
        for (int p = 0; p < NPORTS; p++) begin
            aneg_half_o[p] <= p[0];
            aneg_ten_o[p]  <= p[1];
        end
        phy_link_o <= sys_rst_i ? '0 : link_req_i;
        rx_pause_o <= sys_rst_i ? '0 : (pause_req_i & link_req_i);
    end
endmodule // pmc_phy_model

// file: test/port_mac_control_tb_top.sv
// Self-checking bench for the per-port MAC control block.
// Assumes the design package, header and the PHY model are compiled first.
`timescale 1ns/10ps
`include "pmc_defs.svh"
module port_mac_control_tb_top;
    localparam int NP = 5;                          // Ports under test.
    logic clock_i = 1'b0;                           // 50 MHz clock.
    logic sys_rst_i = 1'b1;                         // Held for 16 cycles.
    logic [2:0] cpu_addr = 3'h0;                    // Direct CPU address.
    logic cpu_wr = 1'b0, cpu_rd = 1'b0, i2c_wr = 1'b0, i2c_rd = 1'b0;
    logic [15:0] cpu_wdata = 16'h0;                 // Index or data word.
    logic [7:0] i2c_addr = 8'h0, i2c_wdata = 8'h0;  // I2C access.
    logic [7:0] cpu_rdata, i2c_rdata, q;            // Read results.
    logic cpu_rvalid, i2c_rvalid;                   // Read answers.
    logic [NP-1:0] idle = '1, cong = '0, lreq = '0, preq = '0;
    logic [NP-1:0] link, ah, at, rxp;               // PHY model outputs.
    pmc_pkg::pmc_stat_t [NP-1:0] stat;              // Per-port controls.
    logic [NP-1:0][15:0] cnt;                       // Pause counters.
    logic [15:0] exp_cnt [NP];                      // Expected counters.
    pmc_pkg::pmc_cfg_t cfg;                         // Stimulus setting.
    int n_fail = 0, total_checks = 0, p, seed;

    always #10 clock_i = ~clock_i;

    pmc_top #(.NPORTS(NP), .CNT_W(16)) dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .cpu_addr_i(cpu_addr), .cpu_wr_i(cpu_wr), .cpu_rd_i(cpu_rd),
        .cpu_wdata_i(cpu_wdata), .cpu_rdata_o(cpu_rdata), .cpu_rvalid_o(cpu_rvalid),
        .i2c_addr_i(i2c_addr), .i2c_wr_i(i2c_wr), .i2c_rd_i(i2c_rd),
        .i2c_wdata_i(i2c_wdata), .i2c_rdata_o(i2c_rdata), .i2c_rvalid_o(i2c_rvalid),
        .frame_idle_i(idle), .rx_pause_i(rxp), .congest_i(cong), .phy_link_i(link),
        .aneg_half_i(ah), .aneg_ten_i(at), .stat_o(stat), .pause_cnt_o(cnt));
    pmc_phy_model #(.NPORTS(NP)) phy (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
        .link_req_i(lreq), .pause_req_i(preq), .phy_link_o(link),
        .aneg_half_o(ah), .aneg_ten_o(at), .rx_pause_o(rxp));

    // Value comparison; case inequality so an unknown never matches.
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Control struct comparison under a mask of fields that are defined.
    task automatic chk_st(input pmc_pkg::pmc_stat_t e, m, g);
        total_checks++;
        if ((g & m) !== (e & m)) begin
            n_fail++;
            $display("[FAIL] stat expected %h seen %h", e & m, g & m);
        end
    endtask
    // Expected controls worked out from the setting and the far side.
    function automatic pmc_pkg::pmc_stat_t exp_st(pmc_pkg::pmc_cfg_t c, int n, logic lk, cg);
        pmc_pkg::pmc_stat_t s;
        logic an;
        an = (c.mode == `PMC_MODE_ANEG);
        s.link_up = (c.mode == `PMC_MODE_UP) || (!c.mode[1] && lk);
        s.phy_poll = !c.mode[1];
        s.aneg_run = an;
        s.half_dup = an ? n[0] : c.half;
        s.ten_mb = an ? n[1] : c.ten_mb;
        s.bp_en = !c.fc_off && s.half_dup && cg;
        s.rx_pause_en = !c.fc_off && !s.half_dup && s.link_up;
        s.tx_pause_en = s.rx_pause_en && !c.asym && cg;
        s.fwd_en = (c.stp == `PMC_STP_FWD);
        s.learn_en = c.stp[1];
        return s;
    endfunction
    // A forced-down port has no defined speed or duplex; a port without link has no defined back pressure.
    function automatic pmc_pkg::pmc_stat_t st_mask(pmc_pkg::pmc_cfg_t c, logic lk);
        pmc_pkg::pmc_stat_t m;
        m = '1;
        m.bp_en = (c.mode == `PMC_MODE_UP) || (!c.mode[1] && lk);
        m.half_dup = (c.mode != `PMC_MODE_DOWN);
        m.ten_mb = (c.mode != `PMC_MODE_DOWN);
        return m;
    endfunction
    // One CPU strobe, released after the taking edge; read data lands then.
    task automatic cpu_op(input logic [2:0] a, input logic wr, input logic [15:0] d);
        @(posedge clock_i);
        cpu_addr <= a;
        cpu_wdata <= d;
        cpu_wr <= wr;
        cpu_rd <= !wr;
        @(posedge clock_i);
        cpu_wr <= 1'b0;
        cpu_rd <= 1'b0;
        #1;
        q = cpu_rdata;
        chk("cpu_rvalid", {15'h0, !wr}, {15'h0, cpu_rvalid});
    endtask
    // One I2C byte access.
    task automatic i2c_op(input logic [7:0] a, input logic wr, input logic [7:0] d);
        @(posedge clock_i);
        i2c_addr <= a;
        i2c_wdata <= d;
        i2c_wr <= wr;
        i2c_rd <= !wr;
        @(posedge clock_i);
        i2c_wr <= 1'b0;
        i2c_rd <= 1'b0;
        #1;
        q = i2c_rdata;
        chk("i2c_rvalid", {15'h0, !wr}, {15'h0, i2c_rvalid});
    endtask
    // Port register access: the CPU loads the index first, then moves a byte.
    task automatic reg_acc(input logic via_i2c, input int n, input logic wr, input logic [7:0] d);
        if (via_i2c) begin
            i2c_op(`PMC_I2C_BASE + 8'(n), wr, d);
        end else begin
            cpu_op(`PMC_IDX_ADDR, 1'b1, `PMC_CPU_BASE + 16'(2 * n));
            cpu_op(`PMC_DATA_ADDR, wr, {8'h0, d});
        end
    endtask
    // Set a port, check its controls, read it back the other way, count a pause.
    task automatic run_cfg(input int n, input pmc_pkg::pmc_cfg_t c, input logic v, lk, cg);
        reg_acc(v, n, 1'b1, c);
        @(posedge clock_i);
        lreq[n] <= lk;
        cong[n] <= cg;
        repeat (4) @(posedge clock_i);
        #1;
        chk_st(exp_st(c, n, lk, cg), st_mask(c, lk), stat[n]);
        reg_acc(!v, n, 1'b0, 8'h0);
        chk("ctl_readback", {8'h0, c}, {8'h0, q});
        @(posedge clock_i);
        preq[n] <= 1'b1;
        @(posedge clock_i);
        preq[n] <= 1'b0;
        repeat (3) @(posedge clock_i);
        #1;
        if (!c.fc_off && lk) exp_cnt[n]++;
        chk("pause_cnt", exp_cnt[n], cnt[n]);
    endtask
    // Single exit: counts, verdict, end of run.
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Watchdog: the whole run needs a few thousand cycles at most.
    initial begin
        #(20 * 50000);
        n_fail++;
        print_verdict();
    end

    // Main sequence.
    initial begin
        for (int i = 0; i < NP; i++) exp_cnt[i] = 16'h0;
        seed = $urandom(2222);
        repeat (16) @(posedge clock_i);
        sys_rst_i <= 1'b0;
        for (int i = 0; i < NP; i++) begin
            reg_acc(i[0], i, 1'b0, 8'h0);
            chk("ctl_reset", {8'h0, `PMC_CTL_RESET}, {8'h0, q});
        end
        $display("test reset values done");
        cpu_op(`PMC_IDX_ADDR, 1'b1, 16'h0001);
        cpu_op(`PMC_DATA_ADDR, 1'b1, 16'h0055);
        cpu_op(`PMC_DATA_ADDR, 1'b0, 16'h0);
        chk("odd_index", 16'h0, {8'h0, q});
        cpu_op(`PMC_IDX_ADDR, 1'b1, 16'(2 * NP));
        cpu_op(`PMC_DATA_ADDR, 1'b0, 16'h0);
        chk("far_index", 16'h0, {8'h0, q});
        i2c_op(8'(NP), 1'b0, 8'h0);
        chk("far_i2c", 16'h0, {8'h0, q});
        reg_acc(1'b1, 0, 1'b0, 8'h0);
        chk("ctl_untouched", {8'h0, `PMC_CTL_RESET}, {8'h0, q});
        $display("test refused accesses done");
        run_cfg(0, 8'hda, 1'b0, 1'b1, 1'b1);
        run_cfg(0, 8'h98, 1'b1, 1'b1, 1'b1);
        run_cfg(0, 8'hb8, 1'b0, 1'b0, 1'b1);
        for (int i = 0; i < 40; i++) begin
            cfg = pmc_pkg::pmc_cfg_t'(8'($urandom));
            if (i < 16) cfg.mode = i[1:0];
            if (i < 16) cfg.stp = i[3:2];
            p = $urandom % NP;
            run_cfg(p, cfg, 1'($urandom), 1'($urandom), 1'($urandom));
        end
        $display("test setting sweep done");
        // Port 0 forwards, then a frame starts and blocking is written.
        reg_acc(1'b0, 0, 1'b1, `PMC_CTL_RESET);
        repeat (4) @(posedge clock_i);
        idle[0] <= 1'b0;
        reg_acc(1'b0, 0, 1'b1, 8'h03);
        repeat (4) @(posedge clock_i);
        #1;
        chk("held_fwd", 16'h1, {15'h0, stat[0].fwd_en});
        chk("held_learn", 16'h1, {15'h0, stat[0].learn_en});
        @(posedge clock_i);
        idle[0] <= 1'b1;
        repeat (4) @(posedge clock_i);
        #1;
        chk("new_fwd", 16'h0, {15'h0, stat[0].fwd_en});
        chk("new_learn", 16'h0, {15'h0, stat[0].learn_en});
        $display("test frame boundary done");
        print_verdict();
    end
endmodule // port_mac_control_tb_top
